// ===== logic/adapter_class_request_decoder.sv
// top of the adapter class request decoder
// -----------------------------------------------------------------
// Overview of operation
// - request code 0,1,3,6,7,14,15,20-28 decoded; 2,4-5,8-13 reserved
// - codes 20 to 28 are the wireless adapter commands
// - time read value field: 0 adjustment, 1 beacon start, 2 channel time
// - selectors: adapter 1 enable 2 reset; pipe 1 pause 2 halt
// - abort pipe ends pending transfers and leaves the pipe idle
// - aborted transfers still report completion, result and received data
// - abort with nonzero value, length or bad pipe index is a request error
// - clear pipe feature changes pipe state; only pause and halt clearable
// - clear pipe feature errors: bad selector, bad index, nonzero length
// - clear adapter feature takes interface number from low index byte
// - clearing controller enable disables the host controller
// - clear adapter feature errors: bad selector, bad interface or nonzero length
// - adapter request naming a missing interface is a request error
// - recipient 4 is a port, 5 a remote pipe, 6 to 31 reserved
// - clearing pause moves the pipe into a not paused substate
// - clearing halt returns the pipe to idle
// -----------------------------------------------------------------
`timescale 1ns/1ps
module adapter_class_request_decoder (
    input wire logic clk,
    input wire logic reset,
    input wire logic setupByteValid,
    input wire logic [7:0] setupByte,
    input wire logic controllerEnableSet,
    input wire logic [3:0] pendingMask,
    output logic requestDone,
    output logic requestStall,
    output logic [7:0] forwardCode,
    output logic forwardValid,
    output logic [1:0] timeSelect,
    output logic [3:0] abortPulse,
    output logic [3:0] pipeReportReq,
    output logic controllerEnabled,
    output logic [15:0] pipeStates
);
    acrd_setup_if setup ();

    acrd_setup_parser uParser (
        .clk(clk),
        .reset(reset),
        .byteValid(setupByteValid),
        .byteData(setupByte),
        .setup(setup)
    );

    // -----------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------
    function automatic logic isWirelessCode(input logic [7:0] code);
        return (code >= acrd_pkg::REQ_ADD_CONTROL_ELEMENT) &&
               (code <= acrd_pkg::REQ_HALT_CHANNEL);
    endfunction : isWirelessCode

    function automatic logic isKnownCode(input logic [7:0] code);
        return (code == acrd_pkg::REQ_GET_STATUS) ||
               (code == acrd_pkg::REQ_CLEAR_FEATURE) ||
               (code == acrd_pkg::REQ_SET_FEATURE) ||
               (code == acrd_pkg::REQ_GET_DESCRIPTOR) ||
               (code == acrd_pkg::REQ_SET_DESCRIPTOR) ||
               (code == acrd_pkg::REQ_ABORT_PIPE) ||
               (code == acrd_pkg::REQ_REINIT_PIPE) ||
               isWirelessCode(code);
    endfunction : isKnownCode

    function automatic logic isPipeSel(input logic [15:0] sel);
        return (sel == acrd_pkg::SEL_PIPE_PAUSE_FEATURE) ||
               (sel == acrd_pkg::SEL_PIPE_HALT_FEATURE);
    endfunction : isPipeSel

    // -----------------------------------------------------------------
    // field decode
    // -----------------------------------------------------------------
    wire [4:0] recipient = setup.reqType[4:0];
    wire recipientPipe = (recipient == acrd_pkg::RCPT_REMOTE_PIPE);
    wire recipientReserved = (recipient >= acrd_pkg::RCPT_RESERVED_LO);
    wire codeKnown = isKnownCode(setup.request);
    wire codeWireless = isWirelessCode(setup.request);
    wire pipeIndexOk = (setup.index < 16'(acrd_pkg::PIPE_COUNT));
    wire [acrd_pkg::PIPE_IDX_W-1:0] pipeIdx = setup.index[acrd_pkg::PIPE_IDX_W-1:0];
    wire [7:0] ifaceNum = setup.index[7:0];
    wire ifaceOk = (ifaceNum == acrd_pkg::ADAPTER_INTERFACE);
    wire lengthZero = (setup.length == 16'h0000);
    wire valueZero = (setup.value == 16'h0000);
    wire isAbort = (setup.reqType == acrd_pkg::TYPE_PIPE_OUT) &&
                   (setup.request == acrd_pkg::REQ_ABORT_PIPE);
    wire isClrPipe = (setup.reqType == acrd_pkg::TYPE_PIPE_OUT) &&
                     (setup.request == acrd_pkg::REQ_CLEAR_FEATURE);
    wire isClrAdapter = (setup.reqType == acrd_pkg::TYPE_ADAPTER_OUT) &&
                        (setup.request == acrd_pkg::REQ_CLEAR_FEATURE);
    wire adapterTarget = (recipient == acrd_pkg::RCPT_INTERFACE) && !recipientPipe;

    wire abortOk = valueZero && lengthZero && pipeIndexOk;
    wire clrPipeOk = isPipeSel(setup.value) && pipeIndexOk && lengthZero;
    wire clrAdapterOk = (setup.value == acrd_pkg::SEL_CONTROLLER_ENABLE) &&
                        lengthZero && ifaceOk;
    wire timeSelOk = (setup.value <= acrd_pkg::TIME_CHANNEL_SEL);
    wire isTime = (setup.request == acrd_pkg::REQ_GET_TIME);
    wire adapterIfaceBad = adapterTarget && !ifaceOk;

    acrd_pkg::acrd_kind_e kind;
    assign kind = isAbort ? acrd_pkg::KIND_ABORT :
                  isClrPipe ? acrd_pkg::KIND_CLR_PIPE :
                  isClrAdapter ? acrd_pkg::KIND_CLR_ADAPTER :
                  acrd_pkg::KIND_OTHER;

    logic accept;
    always_comb begin
        accept = 1'b0;
        case (kind)
            acrd_pkg::KIND_ABORT: accept = abortOk;
            acrd_pkg::KIND_CLR_PIPE: accept = clrPipeOk;
            acrd_pkg::KIND_CLR_ADAPTER: accept = clrAdapterOk;
            default: accept = codeKnown && !recipientReserved && !adapterIfaceBad &&
                              !(isTime && !timeSelOk);
        endcase
    end

    wire doAbort = setup.valid && (kind == acrd_pkg::KIND_ABORT) && accept;
    wire doClrPipe = setup.valid && (kind == acrd_pkg::KIND_CLR_PIPE) && accept;
    wire doClrAdapter = setup.valid && (kind == acrd_pkg::KIND_CLR_ADAPTER) && accept;
    wire clearPause = doClrPipe && (setup.value == acrd_pkg::SEL_PIPE_PAUSE_FEATURE);
    wire clearHalt = doClrPipe && (setup.value == acrd_pkg::SEL_PIPE_HALT_FEATURE);
    wire doForward = setup.valid && accept && (kind == acrd_pkg::KIND_OTHER);

    // -----------------------------------------------------------------
    // remote pipe state table
    // -----------------------------------------------------------------
    logic [3:0] pipeState_r [acrd_pkg::PIPE_COUNT];
    logic [3:0] abort_r;
    logic [3:0] report_r;

    genvar p;
    for (p = 0; p < acrd_pkg::PIPE_COUNT; p++) begin : gPipe
        wire hit = (pipeIdx == acrd_pkg::PIPE_IDX_W'(p));
        logic [3:0] state_nxt;
        always_comb begin
            state_nxt = pipeState_r[p];
            if (doAbort && hit) begin
                state_nxt[acrd_pkg::PST_IDLE] = 1'b1;
            end else if (clearPause && hit) begin
                state_nxt[acrd_pkg::PST_PAUSED] = 1'b0;
            end else if (clearHalt && hit) begin
                state_nxt = acrd_pkg::PIPE_IDLE_STATE;
            end
        end
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                pipeState_r[p] <= acrd_pkg::PIPE_RESET_STATE;
                abort_r[p] <= 1'b0;
                report_r[p] <= 1'b0;
            end else begin
                pipeState_r[p] <= state_nxt;
                abort_r[p] <= doAbort && hit;
                report_r[p] <= doAbort && hit && pendingMask[p];
            end
        end
        assign pipeStates[p*4 +: 4] = pipeState_r[p];
    end

    // -----------------------------------------------------------------
    // controller and answer registers
    // -----------------------------------------------------------------
    logic ctrlEn_r;
    logic done_r;
    logic stall_r;
    logic [7:0] fwdCode_r;
    logic fwdValid_r;
    logic [1:0] timeSel_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrlEn_r <= 1'b0;
        end else if (doClrAdapter) begin
            ctrlEn_r <= 1'b0;
        end else if (controllerEnableSet) begin
            ctrlEn_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_r <= 1'b0;
            stall_r <= 1'b0;
            fwdCode_r <= 8'h00;
            fwdValid_r <= 1'b0;
            timeSel_r <= 2'h0;
        end else begin
            done_r <= setup.valid && accept;
            stall_r <= setup.valid && !accept;
            fwdValid_r <= doForward && (codeWireless || codeKnown);
            if (doForward) begin
                fwdCode_r <= setup.request;
                timeSel_r <= setup.value[1:0];
            end
        end
    end

    assign requestDone = done_r;
    assign requestStall = stall_r;
    assign forwardCode = fwdCode_r;
    assign forwardValid = fwdValid_r;
    assign timeSelect = timeSel_r;
    assign abortPulse = abort_r;
    assign pipeReportReq = report_r;
    assign controllerEnabled = ctrlEn_r;
endmodule : adapter_class_request_decoder

// ===== logic/acrd_pkg.sv
// package of constants for the adapter class request decoder
package acrd_pkg;
    // -----------------------------------------------------------------
    // request codes
    // -----------------------------------------------------------------
    localparam logic [7:0] REQ_GET_STATUS = 8'h00;
    localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
    localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
    localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
    localparam logic [7:0] REQ_SET_DESCRIPTOR = 8'h07;
    localparam logic [7:0] REQ_ABORT_PIPE = 8'h0E;
    localparam logic [7:0] REQ_REINIT_PIPE = 8'h0F;
    localparam logic [7:0] REQ_ADD_CONTROL_ELEMENT = 8'h14;
    localparam logic [7:0] REQ_REMOVE_CONTROL_ELEMENT = 8'h15;
    localparam logic [7:0] REQ_SET_NOTIFY_SLOT_COUNT = 8'h16;
    localparam logic [7:0] REQ_SET_CLUSTER_IDENT = 8'h17;
    localparam logic [7:0] REQ_SET_DEVICE_INFO = 8'h18;
    localparam logic [7:0] REQ_GET_TIME = 8'h19;
    localparam logic [7:0] REQ_SET_STREAM_NUMBER = 8'h1A;
    localparam logic [7:0] REQ_SET_SLOT_MAP = 8'h1B;
    localparam logic [7:0] REQ_HALT_CHANNEL = 8'h1C;
    // -----------------------------------------------------------------
    // request type bytes, recipients, selectors
    // -----------------------------------------------------------------
    localparam logic [7:0] TYPE_PIPE_OUT = 8'h25;
    localparam logic [7:0] TYPE_ADAPTER_OUT = 8'h21;
    localparam logic [4:0] RCPT_INTERFACE = 5'h01;
    localparam logic [4:0] RCPT_PORT = 5'h04;
    localparam logic [4:0] RCPT_REMOTE_PIPE = 5'h05;
    localparam logic [4:0] RCPT_RESERVED_LO = 5'h06;
    localparam logic [15:0] SEL_CONTROLLER_ENABLE = 16'h0001;
    localparam logic [15:0] SEL_CONTROLLER_RESET = 16'h0002;
    localparam logic [15:0] SEL_PIPE_PAUSE_FEATURE = 16'h0001;
    localparam logic [15:0] SEL_PIPE_HALT_FEATURE = 16'h0002;
    localparam logic [15:0] TIME_ADJUSTMENT_SEL = 16'h0000;
    localparam logic [15:0] TIME_BEACON_START_SEL = 16'h0001;
    localparam logic [15:0] TIME_CHANNEL_SEL = 16'h0002;
    // -----------------------------------------------------------------
    // setup layout and pipe table
    // -----------------------------------------------------------------
    localparam int SETUP_BYTES = 8;
    localparam int PIPE_COUNT = 4;
    localparam int PIPE_IDX_W = 2;
    localparam logic [7:0] ADAPTER_INTERFACE = 8'h00;
    localparam logic [2:0] BYTE_TYPE = 3'h0;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // pipe state bits: idle, paused, configured, stalled
    localparam int PST_IDLE = 0;
    localparam int PST_PAUSED = 1;
    localparam int PST_CONFIG = 2;
    localparam int PST_STALLED = 3;
    localparam logic [3:0] PIPE_RESET_STATE = 4'h5;
    localparam logic [3:0] PIPE_IDLE_STATE = 4'h5;
    // decoded request classes
    typedef enum logic [2:0] {
        KIND_NONE, KIND_ABORT, KIND_CLR_PIPE, KIND_CLR_ADAPTER, KIND_OTHER
    } acrd_kind_e;
endpackage : acrd_pkg

// ===== logic/acrd_setup_if.sv
// interface carrying one parsed setup stage
`timescale 1ns/1ps
interface acrd_setup_if;
    logic valid;
    logic [7:0] reqType;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
    modport source (output valid, reqType, request, value, index, length);
    modport sink (input valid, reqType, request, value, index, length);
endinterface : acrd_setup_if

// ===== logic/acrd_setup_parser.sv
// assembles eight setup bytes into little-endian fields
`timescale 1ns/1ps
module acrd_setup_parser (
    input wire logic clk,
    input wire logic reset,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    acrd_setup_if.source setup
);
    logic [2:0] count_r;
    logic [7:0] bytes_r [acrd_pkg::SETUP_BYTES];
    logic done_r;
    wire lastByte = byteValid && (count_r == acrd_pkg::BYTE_LAST);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= acrd_pkg::BYTE_TYPE;
            done_r <= 1'b0;
        end else begin
            done_r <= lastByte;
            if (byteValid) begin
                count_r <= count_r + 3'h1;
            end
        end
    end

    genvar g;
    for (g = 0; g < acrd_pkg::SETUP_BYTES; g++) begin : gByte
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                bytes_r[g] <= 8'h00;
            end else if (byteValid && (count_r == 3'(g))) begin
                bytes_r[g] <= byteData;
            end
        end
    end

    // little-endian field assembly
    assign setup.valid = done_r;
    assign setup.reqType = bytes_r[0];
    assign setup.request = bytes_r[1];
    assign setup.value = {bytes_r[3], bytes_r[2]};
    assign setup.index = {bytes_r[5], bytes_r[4]};
    assign setup.length = {bytes_r[7], bytes_r[6]};
endmodule : acrd_setup_parser

// ===== tb/acrd_assertions.sv
// concurrent checks on the decoder top ports
`timescale 1ns/1ps
module acrd_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic setupByteValid,
    input wire logic [7:0] setupByte,
    input wire logic controllerEnableSet,
    input wire logic [3:0] pendingMask,
    input wire logic requestDone,
    input wire logic requestStall,
    input wire logic [7:0] forwardCode,
    input wire logic forwardValid,
    input wire logic [1:0] timeSelect,
    input wire logic [3:0] abortPulse,
    input wire logic [3:0] pipeReportReq,
    input wire logic controllerEnabled,
    input wire logic [15:0] pipeStates
);
    // ------
    // byte tracking
    // ------
    logic [2:0] byteCnt_r;
    logic lastByte;
    logic [3:0] idleBits;
    assign lastByte = setupByteValid && (byteCnt_r == 3'h7);
    assign idleBits = {pipeStates[12], pipeStates[8], pipeStates[4], pipeStates[0]};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            byteCnt_r <= 3'h0;
        end else if (setupByteValid) begin
            byteCnt_r <= byteCnt_r + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_answer; lastByte |-> ##2 (requestDone ^ requestStall); endproperty
    a_answer: assert property (p_answer)
        else $error("no single answer two cycles after last byte");
    property p_cause; (requestDone || requestStall) |-> $past(lastByte, 2); endproperty
    a_cause: assert property (p_cause)
        else $error("answer without a completed setup");
    property p_abort; |abortPulse |-> $onehot(abortPulse) && requestDone; endproperty
    a_abort: assert property (p_abort)
        else $error("abort pulse not one-hot with done");
    property p_idle; |abortPulse |-> ((idleBits & abortPulse) == abortPulse); endproperty
    a_idle: assert property (p_idle)
        else $error("aborted pipe not idle");
    property p_report; |pipeReportReq |-> ((pipeReportReq & ~abortPulse) == 4'h0); endproperty
    a_report: assert property (p_report)
        else $error("report for a pipe not aborted");
    property p_keep;
        requestStall && !$past(controllerEnableSet) |->
            $stable(pipeStates) && $stable(controllerEnabled) && (abortPulse == 4'h0);
    endproperty
    a_keep: assert property (p_keep)
        else $error("state changed on a stalled request");
    property p_fwd; forwardValid |-> requestDone && !requestStall; endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward without done");
    property p_disable; $fell(controllerEnabled) |-> requestDone; endproperty
    a_disable: assert property (p_disable)
        else $error("controller disabled without a request");
    property p_state; !requestDone |-> $stable(pipeStates); endproperty
    a_state: assert property (p_state)
        else $error("pipe state changed without a request");
endmodule : acrd_assertions
bind adapter_class_request_decoder acrd_assertions u_chk (.clk(clk), .reset(reset),
    .setupByteValid(setupByteValid), .setupByte(setupByte),
    .controllerEnableSet(controllerEnableSet), .pendingMask(pendingMask),
    .requestDone(requestDone), .requestStall(requestStall), .forwardCode(forwardCode),
    .forwardValid(forwardValid), .timeSelect(timeSelect), .abortPulse(abortPulse),
    .pipeReportReq(pipeReportReq), .controllerEnabled(controllerEnabled),
    .pipeStates(pipeStates));

// ===== tb/acrd_host_model.sv
// host model issuing setup stages byte by byte
`timescale 1ns/1ps
module acrd_host_model (
    input wire logic clk,
    output logic setupByteValid,
    output logic [7:0] setupByte
);
    // idle until the bench asks for a stage
    initial begin
        setupByteValid = 1'b0;
        setupByte = 8'h00;
    end
    // lowest byte first, fields little endian
    task automatic send(input logic [63:0] s, input logic more);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            setupByteValid = 1'b1;
            setupByte = s[8*i +: 8];
        end
        if (!more) begin
            @(negedge clk);
            setupByteValid = 1'b0;
            setupByte = ~setupByte;
        end
    endtask : send
endmodule : acrd_host_model

// ===== tb/adapter_class_request_decoder_tb.sv
// self-checking bench for the adapter class request decoder
`timescale 1ns/1ps
module adapter_class_request_decoder_tb;
    typedef struct packed {
        logic [63:0] s;
        logic [1:0] ds;
        logic [3:0] ab;
    } acrd_row_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic controllerEnableSet = 1'b0;
    logic [3:0] pendingMask = 4'h6;
    logic setupByteValid, requestDone, requestStall, forwardValid, controllerEnabled;
    logic [7:0] setupByte, forwardCode, lastFwd;
    logic [1:0] timeSelect;
    logic [3:0] abortPulse, pipeReportReq, seenAb, seenRep;
    logic [15:0] pipeStates;
    int err_total = 0;
    int n_checks = 0;
    int nDone = 0;
    int nStall = 0;
    acrd_row_s rows [18] = '{
        '{64'h0000000200000E25, 2'h2, 4'h4}, '{64'h0000000200010E25, 2'h1, 4'h0},
        '{64'h0001000200000E25, 2'h1, 4'h0}, '{64'h0000000400000E25, 2'h1, 4'h0},
        '{64'h0000000000000E25, 2'h2, 4'h1}, '{64'h0000000100010125, 2'h2, 4'h0},
        '{64'h0000000300020125, 2'h2, 4'h0}, '{64'h0000000100030125, 2'h1, 4'h0},
        '{64'h0000000400010125, 2'h1, 4'h0}, '{64'h0001000000020125, 2'h1, 4'h0},
        '{64'h0000000000010121, 2'h2, 4'h0}, '{64'h0000000000020121, 2'h1, 4'h0},
        '{64'h0002000000010121, 2'h1, 4'h0}, '{64'h0000000100010121, 2'h1, 4'h0},
        '{64'h00000000000319A1, 2'h1, 4'h0}, '{64'h0000000000001A26, 2'h1, 4'h0},
        '{64'h0000000200001621, 2'h1, 4'h0}, '{64'h0000010000010121, 2'h2, 4'h0}};
    logic [7:0] fwd [14] = '{8'h00, 8'h03, 8'h06, 8'h07, 8'h0F, 8'h14, 8'h15, 8'h16,
        8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C};
    adapter_class_request_decoder dut (.clk(clk), .reset(reset),
        .setupByteValid(setupByteValid), .setupByte(setupByte),
        .controllerEnableSet(controllerEnableSet), .pendingMask(pendingMask),
        .requestDone(requestDone), .requestStall(requestStall), .forwardCode(forwardCode),
        .forwardValid(forwardValid), .timeSelect(timeSelect), .abortPulse(abortPulse),
        .pipeReportReq(pipeReportReq), .controllerEnabled(controllerEnabled),
        .pipeStates(pipeStates));
    acrd_host_model host (.clk(clk), .setupByteValid(setupByteValid), .setupByte(setupByte));
    always #25 clk = ~clk;
    // ------
    // pulse monitor
    // ------
    always @(negedge clk) begin
        if (requestDone === 1'b1) nDone++;
        if (requestStall === 1'b1) nStall++;
        if (forwardValid === 1'b1) lastFwd = forwardCode;
        seenAb = seenAb | abortPulse;
        seenRep = seenRep | pipeReportReq;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic issue(input logic [63:0] s, input logic [1:0] ds, input logic [3:0] ab);
        int d0;
        int s0;
        @(posedge clk);
        seenAb = 4'h0;
        seenRep = 4'h0;
        d0 = nDone;
        s0 = nStall;
        host.send(s, 1'b0);
        repeat (2) @(posedge clk);
        chk({8'(nDone - d0), 8'(nStall - s0), seenAb, seenRep},
            {7'h0, ds[1], 7'h0, ds[0], ab, ab & pendingMask});
    endtask : issue
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic pulse_enable;
        @(negedge clk) controllerEnableSet = 1'b1;
        @(negedge clk) controllerEnableSet = 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse_enable
    // ------
    // tests
    // ------
    initial begin
        int d0;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        chk({controllerEnabled, requestDone, requestStall, forwardValid, abortPulse,
            pipeStates}, 24'h005555);
        pulse_enable();
        chk({23'h0, controllerEnabled}, 24'h1);
        foreach (rows[i]) issue(rows[i].s, rows[i].ds, rows[i].ab);
        chk({7'h0, controllerEnabled, pipeStates}, 24'h005555);
        $display("row tests done");
        foreach (fwd[i]) begin
            issue({32'h0, 16'(i % 3), fwd[i], (fwd[i] inside {0, 6, 25}) ? 8'hA1 : 8'h21},
                2'h2, 4'h0);
            chk({14'h0, timeSelect, lastFwd}, {14'h0, 2'(i % 3), fwd[i]});
        end
        for (int c = 2; c < 14; c++) begin
            if (c inside {2, 4, 5, [8:13]}) issue({48'h0, 8'(c), 8'h21}, 2'h1, 4'h0);
        end
        $display("code tests done");
        @(posedge clk);
        d0 = nDone;
        host.send(64'h0000000200000E25, 1'b1);
        host.send(64'h0000000100020125, 1'b0);
        repeat (2) @(posedge clk);
        chk(24'(nDone - d0), 24'h2);
        pulse_enable();
        @(negedge clk) reset = 1'b1;
        @(negedge clk) reset = 1'b0;
        chk({7'h0, controllerEnabled, pipeStates}, 24'h005555);
        issue(64'h0000000300000E25, 2'h2, 4'h8);
        $display("awkward tests done");
        finish_test();
    end
    initial begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule : adapter_class_request_decoder_tb
